// *** common/motion_shaping_consts.vh ***
// constants for the motion delta shaping and finger detect block
// Summary of operation
// - both axes quantized: report only the larger quantized axis, zero the other
// - y quantize enable gates y; reported y is raw y over 2^divisor[6:4]
// - x quantize enable gates x; reported x is raw x over 2^divisor[2:0]
// - slope bit selects linear region gradient: clear gives one, set gives two
// - two-bit offset sets where the linear region begins, at most three
// - motion interrupt only when x plus y exceeds three-bit threshold
// - with cutoff enabled, motion is suppressed while shutter below field times 256
// - two-bit on count at bits 3:2 confirms finger present before asserting
// - two-bit off count at bits 1:0 confirms finger absent before clearing
// - reflectivity value is compared against eight-bit threshold for presence
// - swap bit exchanges x and y reporting; clear means normal
// - y negate bit inverts only reported y
// - x negate bit inverts only reported x
// - squal compared to eight-bit quality threshold when quality detect enabled
// - read-only finger present flag at status bit 0, one means present
`ifndef MOTION_SHAPING_CONSTS_VH
`define MOTION_SHAPING_CONSTS_VH

`define ADDR_QUANT_CTRL 8'h72
`define ADDR_QUANT_GRAD 8'h73
`define ADDR_MOTION_THR 8'h74
`define ADDR_FINGER_CTRL 8'h75
`define ADDR_FINGER_THR 8'h76
`define ADDR_AXIS_ORIENT 8'h77
`define ADDR_QUALITY_THR 8'h78
`define ADDR_REFLECT_VAL 8'h79
`define ADDR_FINGER_STAT 8'h7a

`define RST_QUANT_CTRL 8'h99
`define RST_QUANT_GRAD 8'h02
`define RST_MOTION_THR 8'h00
`define RST_FINGER_CTRL 8'hfa
`define RST_FINGER_THR 8'h1c
`define RST_AXIS_ORIENT 8'h00
`define RST_QUALITY_THR 8'h40

`define MASK_QUANT_GRAD 8'h07
`define MASK_MOTION_THR 8'h07
`define MASK_AXIS_ORIENT 8'he0

`define Y_QEN_BIT 7
`define Y_QDIV_HI 6
`define Y_QDIV_LO 4
`define X_QEN_BIT 3
`define X_QDIV_HI 2
`define X_QDIV_LO 0
`define SLOPE_BIT 2
`define OFFSET_HI 1
`define OFFSET_LO 0
`define MTHR_HI 2
`define MTHR_LO 0
`define CUT_HI 7
`define CUT_LO 4
`define ON_HYST_HI 3
`define ON_HYST_LO 2
`define OFF_HYST_HI 1
`define OFF_HYST_LO 0
`define SWAP_BIT 7
`define YNEG_BIT 6
`define XNEG_BIT 5
`define PRESENT_BIT 0

`define CUT_SCALE_BITS 8

`endif

// *** logic/axis_shaper.v ***
// per-axis magnitude quantizer with linear region shaping
`timescale 1ns/1ps
module axis_shaper #(
    parameter W = 8
) (
    // raw signed delta
    input wire [W-1:0] delta_in,
    // configuration
    input wire quant_en,
    input wire [2:0] divisor,
    input wire slope_two,
    input wire [1:0] offset,
    // shaped magnitude and sign
    output reg [W-1:0] mag_out,
    output wire neg_out
);
    localparam [W:0] MAX_MAG = {2'b00, {(W-1){1'b1}}};
    reg [W:0] mag;
    reg [W:0] q;
    reg [W+1:0] lin;

    assign neg_out = delta_in[W-1];

    always @* begin
        mag = delta_in[W-1] ? ({1'b0, ~delta_in} + 1'b1) : {1'b0, delta_in};
        q = mag >> divisor;
        lin = {1'b0, q};
        if (q > {{(W-1){1'b0}}, offset}) begin
            if (slope_two) begin
                lin = {1'b0, q} + {1'b0, q} - {{W{1'b0}}, offset};
            end else begin
                lin = {1'b0, q};
            end
        end
        if (!quant_en) begin
            lin = {1'b0, mag};
        end
        if (lin > {1'b0, MAX_MAG}) begin
            mag_out = MAX_MAG[W-1:0];
        end else begin
            mag_out = lin[W-1:0];
        end
    end
endmodule

// *** logic/presence_hysteresis.v ***
// debounced presence state with separate on and off counts
`timescale 1ns/1ps
module presence_hysteresis #(
    parameter CW = 2
) (
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // frame step and raw decision
    input wire step,
    input wire candidate,
    // confirmation counts
    input wire [CW-1:0] on_count,
    input wire [CW-1:0] off_count,
    // debounced state
    output reg present_q
);
    reg [CW-1:0] run_q;
    wire [CW-1:0] limit;

    assign limit = present_q ? off_count : on_count;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            present_q <= 1'b0;
            run_q <= {CW{1'b0}};
        end else if (step) begin
            if (candidate == present_q) begin
                run_q <= {CW{1'b0}};
            end else if (run_q >= limit) begin
                present_q <= candidate;
                run_q <= {CW{1'b0}};
            end else begin
                run_q <= run_q + 1'b1;
            end
        end
    end
endmodule

// *** logic/motion_shaping.v ***
// motion delta shaping, motion event and finger detect top
`timescale 1ns/1ps
`include "motion_shaping_consts.vh"
module motion_shaping #(
    parameter W = 8,
    parameter SW = 16
) (
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // register access port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // frame results from the navigation engine
    input wire sample_valid,
    input wire [W-1:0] raw_dx,
    input wire [W-1:0] raw_dy,
    input wire [SW-1:0] shutter,
    input wire [7:0] reflectivity,
    input wire [7:0] squal,
    // engine options
    input wire motion_cutoff_enable,
    input wire quality_detect_enable,
    // shaped motion
    output reg [W-1:0] delta_x,
    output reg [W-1:0] delta_y,
    output reg delta_valid,
    output reg motion_irq,
    // finger state
    output reg finger_present_flag
);
    reg [7:0] quant_ctrl_q;
    reg [7:0] quant_grad_q;
    reg [7:0] motion_thr_q;
    reg [7:0] finger_ctrl_q;
    reg [7:0] finger_thr_q;
    reg [7:0] orient_q;
    reg [7:0] quality_thr_q;
    reg [7:0] reflect_q;
    reg [7:0] rdata_d;

    wire x_quant_enable;
    wire y_quant_enable;
    wire linear_region_slope;
    wire [1:0] linear_region_offset;
    wire [W-1:0] x_mag;
    wire [W-1:0] y_mag;
    wire x_neg;
    wire y_neg;
    wire finger_state;

    reg [W-1:0] xm;
    reg [W-1:0] ym;
    reg [W-1:0] sx;
    reg [W-1:0] sy;
    reg [W-1:0] rep_x_d;
    reg [W-1:0] rep_y_d;
    reg [W:0] mag_sum;
    reg cut_active;
    reg finger_cand;

    reg irq_over;

    // configuration fields
    wire [2:0] x_quant_divisor;
    wire [2:0] y_quant_divisor;
    wire [2:0] irq_threshold;
    wire [W:0] irq_level;
    wire [3:0] cut_field;
    wire [SW-1:0] cut_level;
    wire [1:0] finger_on_hysteresis;
    wire [1:0] finger_off_hysteresis;
    wire [7:0] reflectivity_threshold;
    wire [7:0] quality_detect_threshold;
    wire axis_exchange;
    wire y_negate;
    wire x_negate;

    assign x_quant_enable = quant_ctrl_q[`X_QEN_BIT];
    assign y_quant_enable = quant_ctrl_q[`Y_QEN_BIT];
    assign x_quant_divisor = quant_ctrl_q[`X_QDIV_HI:`X_QDIV_LO];
    assign y_quant_divisor = quant_ctrl_q[`Y_QDIV_HI:`Y_QDIV_LO];
    assign linear_region_slope = quant_grad_q[`SLOPE_BIT];
    assign linear_region_offset = quant_grad_q[`OFFSET_HI:`OFFSET_LO];
    assign irq_threshold = motion_thr_q[`MTHR_HI:`MTHR_LO];
    assign irq_level = {{(W-2){1'b0}}, irq_threshold};
    assign cut_field = finger_ctrl_q[`CUT_HI:`CUT_LO];
    assign finger_on_hysteresis = finger_ctrl_q[`ON_HYST_HI:`ON_HYST_LO];
    assign finger_off_hysteresis = finger_ctrl_q[`OFF_HYST_HI:`OFF_HYST_LO];
    assign reflectivity_threshold = finger_thr_q;
    assign quality_detect_threshold = quality_thr_q;
    assign axis_exchange = orient_q[`SWAP_BIT];
    assign y_negate = orient_q[`YNEG_BIT];
    assign x_negate = orient_q[`XNEG_BIT];

    assign cut_level = {{(SW-4-`CUT_SCALE_BITS){1'b0}}, cut_field,
        {`CUT_SCALE_BITS{1'b0}}};

    // quantization control write
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            quant_ctrl_q <= `RST_QUANT_CTRL;
        end else if (reg_wr && reg_addr == `ADDR_QUANT_CTRL) begin
            quant_ctrl_q <= reg_wdata;
        end
    end

    // gradient write, reserved bits dropped
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            quant_grad_q <= `RST_QUANT_GRAD;
        end else if (reg_wr && reg_addr == `ADDR_QUANT_GRAD) begin
            quant_grad_q <= reg_wdata & `MASK_QUANT_GRAD;
        end
    end

    // motion threshold write, reserved bits dropped
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            motion_thr_q <= `RST_MOTION_THR;
        end else if (reg_wr && reg_addr == `ADDR_MOTION_THR) begin
            motion_thr_q <= reg_wdata & `MASK_MOTION_THR;
        end
    end

    // finger detect control write
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            finger_ctrl_q <= `RST_FINGER_CTRL;
        end else if (reg_wr && reg_addr == `ADDR_FINGER_CTRL) begin
            finger_ctrl_q <= reg_wdata;
        end
    end

    // reflectivity threshold write
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            finger_thr_q <= `RST_FINGER_THR;
        end else if (reg_wr && reg_addr == `ADDR_FINGER_THR) begin
            finger_thr_q <= reg_wdata;
        end
    end

    // orientation write, reserved bits dropped
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            orient_q <= `RST_AXIS_ORIENT;
        end else if (reg_wr && reg_addr == `ADDR_AXIS_ORIENT) begin
            orient_q <= reg_wdata & `MASK_AXIS_ORIENT;
        end
    end

    // quality threshold write
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            quality_thr_q <= `RST_QUALITY_THR;
        end else if (reg_wr && reg_addr == `ADDR_QUALITY_THR) begin
            quality_thr_q <= reg_wdata;
        end
    end

    // read mux; every mapped register reads back, unmapped addresses read zero
    always @* begin
        case (reg_addr)
            `ADDR_QUANT_CTRL: rdata_d = quant_ctrl_q;
            `ADDR_QUANT_GRAD: rdata_d = quant_grad_q;
            `ADDR_MOTION_THR: rdata_d = motion_thr_q;
            `ADDR_FINGER_CTRL: rdata_d = finger_ctrl_q;
            `ADDR_FINGER_THR: rdata_d = finger_thr_q;
            `ADDR_AXIS_ORIENT: rdata_d = orient_q;
            `ADDR_QUALITY_THR: rdata_d = quality_thr_q;
            `ADDR_REFLECT_VAL: rdata_d = reflect_q;
            `ADDR_FINGER_STAT: rdata_d = {7'h00, finger_state};
            default: rdata_d = 8'h00;
        endcase
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end

    axis_shaper #(
        .W(W)
    ) x_shaper (
        .delta_in(raw_dx),
        .quant_en(x_quant_enable),
        .divisor(x_quant_divisor),
        .slope_two(linear_region_slope),
        .offset(linear_region_offset),
        .mag_out(x_mag),
        .neg_out(x_neg)
    );

    axis_shaper #(
        .W(W)
    ) y_shaper (
        .delta_in(raw_dy),
        .quant_en(y_quant_enable),
        .divisor(y_quant_divisor),
        .slope_two(linear_region_slope),
        .offset(linear_region_offset),
        .mag_out(y_mag),
        .neg_out(y_neg)
    );

    // combine axes into reported deltas
    always @* begin
        xm = x_mag;
        ym = y_mag;
        if (x_quant_enable && y_quant_enable) begin
            if (x_mag >= y_mag) begin
                ym = {W{1'b0}};
            end else begin
                xm = {W{1'b0}};
            end
        end
        sx = x_neg ? (~xm + 1'b1) : xm;
        sy = y_neg ? (~ym + 1'b1) : ym;
        rep_x_d = axis_exchange ? sy : sx;
        rep_y_d = axis_exchange ? sx : sy;
        if (x_negate) begin
            rep_x_d = ~rep_x_d + 1'b1;
        end
        if (y_negate) begin
            rep_y_d = ~rep_y_d + 1'b1;
        end
        mag_sum = {1'b0, xm} + {1'b0, ym};
        irq_over = mag_sum > irq_level;
        cut_active = motion_cutoff_enable && (shutter < cut_level);
        finger_cand = (reflectivity > reflectivity_threshold) ||
            (quality_detect_enable && (squal > quality_detect_threshold));
    end

    // reported deltas, zero while cut off
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            delta_x <= {W{1'b0}};
            delta_y <= {W{1'b0}};
        end else if (sample_valid) begin
            if (cut_active) begin
                delta_x <= {W{1'b0}};
                delta_y <= {W{1'b0}};
            end else begin
                delta_x <= rep_x_d;
                delta_y <= rep_y_d;
            end
        end
    end

    // one-cycle strobes after each frame
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            delta_valid <= 1'b0;
            motion_irq <= 1'b0;
        end else begin
            delta_valid <= sample_valid;
            motion_irq <= sample_valid && !cut_active && irq_over;
        end
    end

    // reflectivity of the last frame
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reflect_q <= 8'h00;
        end else if (sample_valid) begin
            reflect_q <= reflectivity;
        end
    end

    // presence flag one cycle behind state
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            finger_present_flag <= 1'b0;
        end else begin
            finger_present_flag <= finger_state;
        end
    end

    presence_hysteresis #(
        .CW(2)
    ) finger_debounce (
        .ref_clk(ref_clk),
        .reset(reset),
        .step(sample_valid),
        .candidate(finger_cand),
        .on_count(finger_on_hysteresis),
        .off_count(finger_off_hysteresis),
        .present_q(finger_state)
    );
endmodule

// *** tb/shaping_checker.sv ***
// port assertions for the motion shaping top
`timescale 1ns/1ps
module shaping_checker #(
    parameter W = 8,
    parameter SW = 16
) (
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // frame path
    input wire sample_valid,
    input wire [W-1:0] raw_dx,
    input wire [W-1:0] raw_dy,
    input wire [SW-1:0] shutter,
    input wire motion_cutoff_enable,
    input wire [W-1:0] delta_x,
    input wire [W-1:0] delta_y,
    input wire delta_valid,
    input wire motion_irq,
    input wire finger_present_flag
);
    function automatic [W:0] mag(input [W-1:0] v);
        mag = {1'b0, (v[W-1] ? ~v + 1'b1 : v)};
    endfunction
    reg [7:0] qc_q, mt_q, fc_q, or_q;
    wire cut = motion_cutoff_enable && shutter < SW'({fc_q[7:4], 8'h00});
    wire [W+1:0] sum = mag(delta_x) + mag(delta_y);
    // shadow of the configuration registers
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            qc_q <= 8'h99;
            mt_q <= 8'h00;
            fc_q <= 8'hfa;
            or_q <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == 8'h72) qc_q <= reg_wdata;
            if (reg_addr == 8'h74) mt_q <= reg_wdata & 8'h07;
            if (reg_addr == 8'h75) fc_q <= reg_wdata;
            if (reg_addr == 8'h77) or_q <= reg_wdata & 8'he0;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    AST_VALID_LAT: assert property (sample_valid |=> delta_valid)
        else $error("delta_valid missing");
    AST_NO_SPURIOUS: assert property (!sample_valid |=> !delta_valid)
        else $error("delta_valid without frame");
    AST_IRQ_PAIR: assert property (motion_irq |-> delta_valid)
        else $error("motion_irq outside delta_valid");
    AST_IRQ_SUM: assert property (delta_valid |->
        motion_irq == (sum > $past(mt_q))) else $error("motion_irq wrong");
    AST_CUTOFF: assert property (sample_valid && cut |=>
        delta_x == 0 && delta_y == 0) else $error("cut motion reported");
    AST_PASS: assert property (sample_valid && !cut && qc_q[7] == 0
        && qc_q[3] == 0 && or_q == 0 && raw_dx != 8'h80 && raw_dy != 8'h80
        |=> delta_x == $past(raw_dx) && delta_y == $past(raw_dy))
        else $error("plain deltas altered");
    AST_FLAG_TIMING: assert property ($changed(finger_present_flag)
        |-> $past(sample_valid, 2)) else $error("flag moved off frame");
    AST_STATUS_RD: assert property (reg_rd && reg_addr == 8'h7a
        |=> reg_rdata == {7'h00, finger_present_flag})
        else $error("status read differs from flag");
    cover property (sample_valid && cut);
    cover property (motion_irq);
    cover property ($rose(finger_present_flag));
endmodule
bind motion_shaping shaping_checker #(.W(W), .SW(SW)) chk (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_valid(sample_valid), .raw_dx(raw_dx),
    .raw_dy(raw_dy), .shutter(shutter),
    .motion_cutoff_enable(motion_cutoff_enable), .delta_x(delta_x),
    .delta_y(delta_y), .delta_valid(delta_valid), .motion_irq(motion_irq),
    .finger_present_flag(finger_present_flag)
);

// *** tb/host_model.sv ***
// host model driving the register access port
`timescale 1ns/1ps
module host_model (
    // clock
    input wire ref_clk,
    // register port
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] reg_wdata = 8'h00,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    input wire [7:0] reg_rdata
);
    // one strobe cycle per access, data line scrambled after
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic wr(input logic [7:0] a, d);
        acc(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        acc(1'b0, a, 8'h00);
        d = reg_rdata;
    endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for motion shaping and finger detect
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 0;
    logic reset = 1;
    logic sample_valid = 0;
    logic [7:0] raw_dx = 0, raw_dy = 0, reflectivity = 0, squal = 0;
    logic [15:0] shutter = 16'h0f00;
    logic motion_cutoff_enable = 0;
    logic quality_detect_enable = 0;
    wire [7:0] reg_addr, reg_wdata, reg_rdata, delta_x, delta_y;
    wire reg_wr, reg_rd, delta_valid, motion_irq, finger_present_flag;
    int bad_count = 0;
    int tests_run = 0;
    logic [7:0] v;
    // config, raw x/y, expected x/y/irq
    logic [63:0] rows [8] = '{64'h9902001004080001, 64'h8000a00201ff0200,
        64'h0a0560e0030ffd01, 64'h88000004fc040001, 64'h8800000106000601,
        64'h0000c0020505fe01, 64'h0807000300030000, 64'h00000005fe05fe01};
    logic [7:0] rst_v [7] = '{8'h99, 8'h02, 8'h00, 8'hfa, 8'h1c, 8'h00, 8'h40};
    always #2 ref_clk = ~ref_clk;
    host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    motion_shaping #(.W(8), .SW(16)) dut (.ref_clk(ref_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
        .raw_dx(raw_dx), .raw_dy(raw_dy), .shutter(shutter),
        .reflectivity(reflectivity), .squal(squal),
        .motion_cutoff_enable(motion_cutoff_enable),
        .quality_detect_enable(quality_detect_enable), .delta_x(delta_x),
        .delta_y(delta_y), .delta_valid(delta_valid), .motion_irq(motion_irq),
        .finger_present_flag(finger_present_flag));
    task automatic chk(input string n, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic frame(input logic [7:0] x, y, r, s);
        @(posedge ref_clk);
        #1;
        {raw_dx, raw_dy, reflectivity, squal} = {x, y, r, s};
        sample_valid = 1;
        @(posedge ref_clk);
        #1;
        sample_valid = 0;
        chk("delta_valid", 8'h01, {7'h0, delta_valid});
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        reset = 0;
        for (int i = 0; i < 7; i++) begin
            host.rd(8'h72 + 8'(i), v);
            chk("reset value", rst_v[i], v);
        end
        host.rd(8'h71, v);
        chk("unmapped", 8'h00, v);
        host.wr(8'h73, 8'hff);
        host.rd(8'h73, v);
        chk("gradient", 8'h07, v);
        host.wr(8'h77, 8'hff);
        host.rd(8'h77, v);
        chk("orientation", 8'he0, v);
        host.wr(8'h74, 8'h03);
        foreach (rows[i]) begin
            host.wr(8'h72, rows[i][63:56]);
            host.wr(8'h73, rows[i][55:48]);
            host.wr(8'h77, rows[i][47:40]);
            frame(rows[i][39:32], rows[i][31:24], 8'h00, 8'h00);
            chk("delta_x", rows[i][23:16], delta_x);
            chk("delta_y", rows[i][15:8], delta_y);
            chk("motion_irq", rows[i][7:0], {7'h0, motion_irq});
        end
        motion_cutoff_enable = 1;
        shutter = 16'h0eff;
        frame(8'h10, 8'h10, 8'h00, 8'h00);
        chk("cut x", 8'h00, delta_x);
        chk("cut y", 8'h00, delta_y);
        chk("cut irq", 8'h00, {7'h0, motion_irq});
        shutter = 16'h0f00;
        frame(8'h05, 8'h00, 8'h00, 8'h00);
        chk("uncut x", 8'h05, delta_x);
        motion_cutoff_enable = 0;
        quality_detect_enable = 1;
        repeat (3) frame(8'h00, 8'h00, 8'h1c, 8'h41);
        host.rd(8'h7a, v);
        chk("quality on", 8'h01, v);
        chk("flag", 8'h01, {7'h0, finger_present_flag});
        host.wr(8'h75, 8'hf8);
        frame(8'h00, 8'h00, 8'h1c, 8'h40);
        host.rd(8'h7a, v);
        chk("off", 8'h00, v);
        quality_detect_enable = 0;
        repeat (2) frame(8'h00, 8'h00, 8'h1d, 8'hff);
        frame(8'h00, 8'h00, 8'h00, 8'hff);
        repeat (2) frame(8'h00, 8'h00, 8'h1d, 8'hff);
        host.rd(8'h7a, v);
        chk("run broken", 8'h00, v);
        frame(8'h05, 8'h00, 8'h1d, 8'hff);
        chk("frame x", 8'h05, delta_x);
        host.rd(8'h7a, v);
        chk("reflect on", 8'h01, v);
        host.wr(8'h79, 8'h55);
        host.rd(8'h79, v);
        chk("reflect value", 8'h1d, v);
        // mid-run reset clears state and registers
        @(posedge ref_clk);
        #1;
        reset = 1;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("reset x", 8'h00, delta_x);
        chk("reset flag", 8'h00, {7'h0, finger_present_flag});
        reset = 0;
        host.rd(8'h72, v);
        chk("reset again", 8'h99, v);
        host.rd(8'h7a, v);
        chk("status reset", 8'h00, v);
        finish_test();
    end
endmodule
